/* hdl/srb_regs.svh */
// Register offsets, field masks and bit positions of the sleep reset bank
`ifndef SRB_REGS_SVH
`define SRB_REGS_SVH
`define SRB_OFS_HOST_EN 8'h3c
`define SRB_OFS_CTRL_EN 8'h40
`define SRB_OFS_HOST_STS 8'h50
`define SRB_OFS_CTRL_STS 8'h54
`define SRB_EN_RST 32'h0000_0000
`define SRB_HOST_WR_MASK 32'h001f_fc0f
`define SRB_HOST_RST_MASK 32'h0019_100e
`define SRB_CTRL_WR_MASK 32'hc7f0_3ff7
`define SRB_CTRL_RST_MASK 32'hc7f0_3ff7
`define SRB_HOST_SCRATCH_BIT 20
`define SRB_HOST_ESPI_BIT 19
`define SRB_HOST_KBD_BIT 16
`define SRB_HOST_GCFG_BIT 12
`define SRB_HOST_FWHB_BIT 3
`define SRB_HOST_FWHA_BIT 2
`define SRB_HOST_UART_BIT 1
`define SRB_HOST_SPARE_BIT 0
`define SRB_CTRL_TMRB_BIT 31
`define SRB_CTRL_PWM7_BIT 26
`define SRB_CTRL_FAN_SPEED_INPUT_3_BIT 13
`define SRB_CTRL_WDT_BIT 9
`define SRB_CTRL_CPU_BIT 8
`define SRB_CTRL_DMA_BIT 6
`define SRB_CTRL_IRQ_BIT 0
`endif

/* hdl/srb_pkg.sv */
// Types and address decode shared by the sleep reset bank
package srb_pkg;
`include "srb_regs.svh"

  // Register bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } srb_bus_req_t;

  // Register selected by an address
  typedef enum {
    SRB_SEL_NONE,
    SRB_SEL_HOST_EN,
    SRB_SEL_CTRL_EN,
    SRB_SEL_HOST_STS,
    SRB_SEL_CTRL_STS
  } srb_sel_t;

  // Address decode used by both read and write paths
  function automatic srb_sel_t srb_decode(input logic [7:0] addr);
    srb_sel_t sel;
    sel = SRB_SEL_NONE;
    case (addr)
      `SRB_OFS_HOST_EN: sel = SRB_SEL_HOST_EN;
      `SRB_OFS_CTRL_EN: sel = SRB_SEL_CTRL_EN;
      `SRB_OFS_HOST_STS: sel = SRB_SEL_HOST_STS;
      `SRB_OFS_CTRL_STS: sel = SRB_SEL_CTRL_STS;
      default: sel = SRB_SEL_NONE;
    endcase
    return sel;
  endfunction
endpackage

/* hdl/srb_sync.sv */
// Two-flop synchroniser for a vector of sleep indications
`timescale 1ns/1ps
module srb_sync import srb_pkg::*; #(
  parameter int W = 32
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [W-1:0] i_async, // Unsynchronised levels
  output logic [W-1:0] o_sync // Synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage only feeds the second
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // Both stages clear on reset
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule

/* hdl/srb_rst_gen.sv */
// Per-block sleep reset generation from enable and sleep state
`timescale 1ns/1ps
module srb_rst_gen import srb_pkg::*; #(
  parameter int W = 32,
  parameter logic [W-1:0] MASK = '1
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [W-1:0] i_en, // Reset-on-sleep enables
  input wire logic [W-1:0] i_asleep, // Synchronised sleep state
  output logic [W-1:0] o_rst // Registered block resets
);
  logic [W-1:0] rst_q;
  logic [W-1:0] rst_d;

  // One reset flop per block position
  for (genvar g = 0; g < W; g++) begin : g_bit
    // Held only while asleep and enabled
    always_comb begin
      rst_d[g] = MASK[g] & i_en[g] & i_asleep[g];
    end

    // Registered so block resets are glitch free
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        rst_q[g] <= 1'b0;
      end else begin
        rst_q[g] <= rst_d[g];
      end
    end
  end

  assign o_rst = rst_q;
endmodule

/* hdl/srb_top.sv */
// Sleep reset enable bank: two enable registers and block resets
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "srb_regs.svh"
module srb_top import srb_pkg::*; (
  input wire logic i_clk_sys, // System clock, 25 MHz
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after strobe
  input wire logic [31:0] i_host_sleep, // Host-side blocks asleep
  input wire logic [31:0] i_ctrl_sleep, // Controller blocks asleep
  output logic [31:0] o_host_blk_rst, // Host-side block resets
  output logic [31:0] o_ctrl_blk_rst, // Controller block resets
  output logic o_shared_flash_bridge_rst // Flash bridge reset
);
  srb_bus_req_t req;
  srb_sel_t wr_sel;
  srb_sel_t rd_sel;
  logic [31:0] host_en_q;
  logic [31:0] host_en_d;
  logic [31:0] ctrl_en_q;
  logic [31:0] ctrl_en_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] host_sleep_s;
  logic [31:0] ctrl_sleep_s;
  logic [31:0] host_rst;
  logic [31:0] ctrl_rst;

  // Bundle the bus and decode once per strobe kind
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign wr_sel = req.wr ? srb_decode(req.addr) : SRB_SEL_NONE;
  assign rd_sel = req.rd ? srb_decode(req.addr) : SRB_SEL_NONE;

  // Sleep indications come from gated block clocks
  srb_sync #(
    .W(32)
  ) u_host_sync (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_async(i_host_sleep),
    .o_sync(host_sleep_s)
  );

  srb_sync #(
    .W(32)
  ) u_ctrl_sync (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_async(i_ctrl_sleep),
    .o_sync(ctrl_sleep_s)
  );

  // Host-side resets, only blocks that own a bit
  srb_rst_gen #(
    .W(32),
    .MASK(`SRB_HOST_RST_MASK)
  ) u_host_rst (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_en(host_en_q),
    .i_asleep(host_sleep_s),
    .o_rst(host_rst)
  );

  // Controller-side resets
  srb_rst_gen #(
    .W(32),
    .MASK(`SRB_CTRL_RST_MASK)
  ) u_ctrl_rst (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_en(ctrl_en_q),
    .i_asleep(ctrl_sleep_s),
    .o_rst(ctrl_rst)
  );

  // Held resets keep sleeping blocks from taking writes
  assign o_host_blk_rst = host_rst;
  assign o_ctrl_blk_rst = ctrl_rst;
  // Flash bridge follows the serial host interface reset
  assign o_shared_flash_bridge_rst = host_rst[`SRB_HOST_ESPI_BIT];

  // Enable register next values
  always_comb begin
    host_en_d = host_en_q;
    ctrl_en_d = ctrl_en_q;
    if (wr_sel == SRB_SEL_HOST_EN) begin
      host_en_d = req.wdata & `SRB_HOST_WR_MASK;
    end
    if (wr_sel == SRB_SEL_CTRL_EN) begin
      ctrl_en_d = req.wdata & `SRB_CTRL_WR_MASK;
    end
  end

  // Enable registers clear on system reset
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      host_en_q <= `SRB_EN_RST;
      ctrl_en_q <= `SRB_EN_RST;
    end else begin
      host_en_q <= host_en_d;
      ctrl_en_q <= ctrl_en_d;
    end
  end

  // Read mux; unmapped and idle cycles return zero
  always_comb begin
    case (rd_sel)
      SRB_SEL_HOST_EN: rdata_d = host_en_q;
      SRB_SEL_CTRL_EN: rdata_d = ctrl_en_q;
      SRB_SEL_HOST_STS: rdata_d = host_rst;
      SRB_SEL_CTRL_STS: rdata_d = ctrl_rst;
      default: rdata_d = '0;
    endcase
  end

  // Read data register
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // Checks on register and reset behaviour
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  chk_host_bit_store: assert property (
    i_wr && i_addr == `SRB_OFS_HOST_EN
    |=> host_en_q[`SRB_HOST_SCRATCH_BIT] ==
        $past(i_wdata[`SRB_HOST_SCRATCH_BIT])
  ) else $error("host enable bit not stored");

  chk_host_write_mask: assert property (
    i_wr && i_addr == `SRB_OFS_HOST_EN
    |=> host_en_q == ($past(i_wdata) & `SRB_HOST_WR_MASK)
  ) else $error("host enable write wrong");

  chk_ctrl_write_mask: assert property (
    i_wr && i_addr == `SRB_OFS_CTRL_EN
    |=> ctrl_en_q == ($past(i_wdata) & `SRB_CTRL_WR_MASK)
  ) else $error("controller enable write wrong");

  chk_host_readback: assert property (
    i_rd && i_addr == `SRB_OFS_HOST_EN
    |=> o_rdata == $past(host_en_q)
        && (o_rdata & ~`SRB_HOST_WR_MASK) == '0
  ) else $error("host enable readback wrong");

  chk_unmapped_zero: assert property (
    i_rd && srb_decode(i_addr) == SRB_SEL_NONE |=> o_rdata == '0
  ) else $error("unmapped read not zero");

  chk_enables_hold: assert property (
    !i_wr |=> $stable(host_en_q) && $stable(ctrl_en_q)
  ) else $error("enables changed without write");

  chk_flash_bridge_pair: assert property (
    o_shared_flash_bridge_rst == o_host_blk_rst[`SRB_HOST_ESPI_BIT]
  ) else $error("flash bridge reset not with serial host");

  chk_host_rst_cause: assert property (
    ##1 o_host_blk_rst ==
    ($past(host_en_q & host_sleep_s) & `SRB_HOST_RST_MASK)
  ) else $error("host reset not from enable and sleep");

  chk_ctrl_rst_cause: assert property (
    ##1 o_ctrl_blk_rst ==
    ($past(ctrl_en_q & ctrl_sleep_s) & `SRB_CTRL_RST_MASK)
  ) else $error("controller reset not from enable and sleep");

  chk_cpu_sleep_rst: assert property (
    ctrl_en_q[`SRB_CTRL_CPU_BIT] && i_ctrl_sleep[`SRB_CTRL_CPU_BIT]
    && !i_wr [*3]
    |=> o_ctrl_blk_rst[`SRB_CTRL_CPU_BIT]
  ) else $error("processor not reset while asleep");

  chk_spare_no_rst: assert property (
    o_host_blk_rst[`SRB_HOST_SPARE_BIT] == 1'b0
    && (o_host_blk_rst & ~`SRB_HOST_RST_MASK) == '0
  ) else $error("reset driven on a storage-only bit");

  chk_wake_release: assert property (
    $fell(host_sleep_s[`SRB_HOST_UART_BIT])
    |=> !o_host_blk_rst[`SRB_HOST_UART_BIT]
  ) else $error("serial reset not released on wake");

  chk_irq_disabled: assert property (
    !ctrl_en_q[`SRB_CTRL_IRQ_BIT] |=> !o_ctrl_blk_rst[`SRB_CTRL_IRQ_BIT]
  ) else $error("interrupt block reset while disabled");

  chk_wdt_enable_path: assert property (
    i_wr && i_addr == `SRB_OFS_CTRL_EN && i_wdata[`SRB_CTRL_WDT_BIT]
    && ctrl_sleep_s[`SRB_CTRL_WDT_BIT] ##1 ctrl_sleep_s[`SRB_CTRL_WDT_BIT]
    |=> o_ctrl_blk_rst[`SRB_CTRL_WDT_BIT]
  ) else $error("watchdog reset late after enable");

  chk_status_read: assert property (
    i_rd && i_addr == `SRB_OFS_CTRL_STS |=> o_rdata == $past(ctrl_rst)
  ) else $error("controller status readback wrong");

  chk_host_sts_read: assert property (
    i_rd && i_addr == `SRB_OFS_HOST_STS |=> o_rdata == $past(host_rst)
  ) else $error("host status readback wrong");

  chk_ctrl_readback: assert property (
    i_rd && i_addr == `SRB_OFS_CTRL_EN
    |=> o_rdata == $past(ctrl_en_q)
        && (o_rdata & ~`SRB_CTRL_WR_MASK) == '0
  ) else $error("controller enable readback wrong");

  chk_rdata_idle_zero: assert property (
    !i_rd |=> o_rdata == '0
  ) else $error("read data not zero when idle");

  chk_sts_wr_ignored: assert property (
    i_wr && (i_addr == `SRB_OFS_HOST_STS || i_addr == `SRB_OFS_CTRL_STS)
    |=> $stable(host_en_q) && $stable(ctrl_en_q)
  ) else $error("status write changed an enable");

  chk_ctrl_rsvd_no_rst: assert property (
    (o_ctrl_blk_rst & ~`SRB_CTRL_RST_MASK) == '0
  ) else $error("reset driven on a reserved bit");

  chk_scratch_rst: assert property (
    host_en_q[`SRB_HOST_SCRATCH_BIT] && host_sleep_s[`SRB_HOST_SCRATCH_BIT]
    |=> o_host_blk_rst[`SRB_HOST_SCRATCH_BIT]
  ) else $error("scratch block not reset while asleep");

  chk_kbd_rst: assert property (
    host_en_q[`SRB_HOST_KBD_BIT] && host_sleep_s[`SRB_HOST_KBD_BIT]
    |=> o_host_blk_rst[`SRB_HOST_KBD_BIT]
  ) else $error("keyboard emulator not reset while asleep");

  chk_gcfg_rst: assert property (
    host_en_q[`SRB_HOST_GCFG_BIT] && host_sleep_s[`SRB_HOST_GCFG_BIT]
    |=> o_host_blk_rst[`SRB_HOST_GCFG_BIT]
  ) else $error("global config not reset while asleep");

  chk_fwh_a_rst: assert property (
    host_en_q[`SRB_HOST_FWHA_BIT] && host_sleep_s[`SRB_HOST_FWHA_BIT]
    |=> o_host_blk_rst[`SRB_HOST_FWHA_BIT]
  ) else $error("firmware hub port a not reset while asleep");

  chk_fwh_b_rst: assert property (
    host_en_q[`SRB_HOST_FWHB_BIT] && host_sleep_s[`SRB_HOST_FWHB_BIT]
    |=> o_host_blk_rst[`SRB_HOST_FWHB_BIT]
  ) else $error("firmware hub port b not reset while asleep");

  chk_timer_b_rst: assert property (
    ctrl_en_q[`SRB_CTRL_TMRB_BIT] && ctrl_sleep_s[`SRB_CTRL_TMRB_BIT]
    |=> o_ctrl_blk_rst[`SRB_CTRL_TMRB_BIT]
  ) else $error("timer b not reset while asleep");

  chk_pwm_top_rst: assert property (
    ctrl_en_q[`SRB_CTRL_PWM7_BIT] && ctrl_sleep_s[`SRB_CTRL_PWM7_BIT]
    |=> o_ctrl_blk_rst[`SRB_CTRL_PWM7_BIT]
  ) else $error("pulse-width output 7 not reset while asleep");

  chk_fan_top_rst: assert property (
    ctrl_en_q[`SRB_CTRL_FAN_SPEED_INPUT_3_BIT] && ctrl_sleep_s[`SRB_CTRL_FAN_SPEED_INPUT_3_BIT]
    |=> o_ctrl_blk_rst[`SRB_CTRL_FAN_SPEED_INPUT_3_BIT]
  ) else $error("fan speed input 3 not reset while asleep");

  chk_dma_rst: assert property (
    ctrl_en_q[`SRB_CTRL_DMA_BIT] && ctrl_sleep_s[`SRB_CTRL_DMA_BIT]
    |=> o_ctrl_blk_rst[`SRB_CTRL_DMA_BIT]
  ) else $error("DMA block not reset while asleep");

  // Main scenarios
  cov_espi_sleep_rst: cover property (
    o_shared_flash_bridge_rst ##[1:20] !o_shared_flash_bridge_rst
  );

  cov_cpu_sleep_rst: cover property (
    $rose(o_ctrl_blk_rst[`SRB_CTRL_CPU_BIT])
  );

  cov_write_then_read: cover property (
    i_wr && i_addr == `SRB_OFS_HOST_EN ##1 i_rd
    && i_addr == `SRB_OFS_HOST_EN
  );

  cov_unmapped_read: cover property (
    i_rd && srb_decode(i_addr) == SRB_SEL_NONE
  );

  cov_status_read: cover property (
    i_rd && i_addr == `SRB_OFS_HOST_STS
  );
endmodule

/* verif/sleep_reset_enable_bank_tb.sv */
// Self-checking bench for the sleep reset enable bank
`timescale 1ns/1ps
module sleep_reset_enable_bank_tb;
  import srb_pkg::*;
  localparam logic [31:0] HMSK = 32'h001f_fc0f; // Host storage bits
  localparam logic [31:0] HRST = 32'h0019_100e; // Host bits with a block
  localparam logic [31:0] CMSK = 32'hc7f0_3ff7; // Controller enable bits
  logic i_clk_sys;
  logic i_arst_n;
  logic i_wr;
  logic i_rd;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic [31:0] i_host_sleep;
  logic [31:0] i_ctrl_sleep;
  logic [31:0] o_rdata;
  logic [31:0] o_host_blk_rst;
  logic [31:0] o_ctrl_blk_rst;
  logic o_shared_flash_bridge_rst;
  logic [31:0] rdv;
  int err_total;
  int n_compared;

  srb_top u_dut (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_host_sleep(i_host_sleep),
    .i_ctrl_sleep(i_ctrl_sleep),
    .o_host_blk_rst(o_host_blk_rst),
    .o_ctrl_blk_rst(o_ctrl_blk_rst),
    .o_shared_flash_bridge_rst(o_shared_flash_bridge_rst)
  );

  // Clock, 40 ns period
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // Compare a seen value against the expected one
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Register write, one strobe cycle then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    rdv = o_rdata;
    @(posedge i_clk_sys);
  endtask

  // Wait a number of edges, then step off the edge
  task automatic after(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // Verdict and end of run
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Reset values of both enable registers
  task automatic t_defaults;
    rd(8'h3c);
    check("host_en", rdv, 32'h0);
    rd(8'h40);
    check("ctrl_en", rdv, 32'h0);
    $display("defaults done");
  endtask

  // Writable bits, reserved bits and unmapped places
  task automatic t_regs;
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c);
    check("host_en", rdv, HMSK);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    check("ctrl_en", rdv, CMSK);
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44);
    check("unmapped", rdv, 32'h0);
    wr(8'h50, 32'h0);
    rd(8'h3c);
    check("sts_write", rdv, HMSK);
    $display("registers done");
  endtask

  // One sleeping block at a time, all enables set
  task automatic t_sweep;
    for (int b = 0; b < 32; b++) begin
      i_host_sleep <= 32'h1 << b;
      i_ctrl_sleep <= 32'h1 << b;
      after(3);
      check("host_rst", o_host_blk_rst, HRST & (32'h1 << b));
      check("ctrl_rst", o_ctrl_blk_rst, CMSK & (32'h1 << b));
      check("flash_rst", {31'h0, o_shared_flash_bridge_rst},
            {31'h0, b == 19});
      @(posedge i_clk_sys);
    end
    $display("sweep done");
  endtask

  // Reset held only while asleep and enabled
  task automatic t_release;
    i_host_sleep <= 32'hffff_ffff;
    i_ctrl_sleep <= 32'hffff_ffff;
    after(3);
    check("host_all", o_host_blk_rst, HRST);
    check("ctrl_all", o_ctrl_blk_rst, CMSK);
    @(posedge i_clk_sys);
    rd(8'h50);
    check("host_sts", rdv, HRST);
    rd(8'h54);
    check("ctrl_sts", rdv, CMSK);
    wr(8'h40, 32'h0);
    #1;
    check("ctrl_off", o_ctrl_blk_rst, 32'h0);
    @(posedge i_clk_sys);
    wr(8'h40, 32'h0000_0200);
    #1;
    check("wdt_on", o_ctrl_blk_rst, 32'h0000_0200);
    @(posedge i_clk_sys);
    i_host_sleep <= 32'h0;
    after(2);
    check("host_hold", o_host_blk_rst, HRST);
    after(1);
    check("host_wake", o_host_blk_rst, 32'h0);
    @(posedge i_clk_sys);
    $display("release done");
  endtask

  // Second reset in mid-run clears the registers
  task automatic t_rst_mid;
    wr(8'h40, CMSK);
    after(1);
    check("ctrl_pre", o_ctrl_blk_rst, CMSK);
    @(posedge i_clk_sys);
    i_arst_n <= 1'b0;
    after(1);
    check("rst_host", o_host_blk_rst, 32'h0);
    check("rst_ctrl", o_ctrl_blk_rst, 32'h0);
    @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    after(1);
    check("rel_ctrl1", o_ctrl_blk_rst, 32'h0);
    after(1);
    check("rel_ctrl2", o_ctrl_blk_rst, 32'h0);
    @(posedge i_clk_sys);
    rd(8'h3c);
    check("host_en", rdv, 32'h0);
    rd(8'h40);
    check("ctrl_en", rdv, 32'h0);
    $display("mid reset done");
  endtask

  // Main sequence
  initial begin
    i_arst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_host_sleep = 32'h0;
    i_ctrl_sleep = 32'h0;
    repeat (8) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    @(posedge i_clk_sys);
    t_defaults;
    t_regs;
    t_sweep;
    t_release;
    t_rst_mid;
    close_out;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_total++;
    close_out;
  end
endmodule
